// ---- pcr_device.sv ----
// Device end: supply monitor, blackout control, internal reset and chip reset pin.
//
// What this block, the host end and the firmware do
// - Power control low holds all internal blocks reset.
// - Reset pin low during reset, released after control high.
// - Monitor output low until battery reaches 1.6 V.
// - Battery below blackout threshold drops monitor output low.
// - Monitor output low holds I/O and logic safe.
// - Looped back, device self-resets and follows supply.
// - Delay from power control rise to reset release.
// - Host reset holds power control low 10 ms.
// - Battery first; others on 1 ms before release.
// - Power down together or battery removed last.
// - External control keeps control low 600 us.
// - Host may drop control before removing supplies.
// - Blackout asserts below 1.6 V, clears above 1.625 V.
// - Blackout comparator enabled by default at power up.
// - Monitor disabled after power up; firmware re-enables.
// - Firmware enables monitor only in high power modes.
// - Brownout in low power auto-enables blackout comparator.
`include "pcr_defs.svh"
`timescale 1ns/1ps

module pcr_device #(
	parameter int unsigned RELEASE_DELAY_CYC = `PCR_RELEASE_CYC
) (
	// Clock and synchronous active-low reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Link pins.
	pcr_link_if.device link,
	// Battery level in millivolts from the always-on sampler.
	input wire logic [`PCR_MV_W-1:0] battery_supply_mv,
	// Power mode and firmware controls.
	input wire logic fw_blackout_en,
	input wire logic low_power_mode,
	input wire logic brownout_event,
	// Internal reset, safe-state hold and status.
	output logic blocks_rst_n,
	output logic io_safe_hold,
	output logic blackout_active,
	output logic monitor_enabled,
	output logic chip_running
);

	// A zero delay would wrap the count target, holding reset for about 2^32 cycles.
	generate
		if (RELEASE_DELAY_CYC < 1)
		begin : g_bad_delay
			$error("pcr_device: RELEASE_DELAY_CYC must be at least 1");
		end
	endgenerate

	// Two-stage synchronisers for the pin and the sampled battery code.
	logic pc_meta_reg;
	logic pc_sync_reg;
	logic [`PCR_MV_W-1:0] mv_meta_reg;
	logic [`PCR_MV_W-1:0] mv_sync_reg;
	// Blackout monitor state.
	logic blackout_reg;
	logic powered_once_reg;
	logic auto_en_reg;
	logic mon_en;
	// Chip reset pin sequencer.
	pcr_pkg::pcr_rst_state_t rst_state_reg;
	logic [31:0] delay_cnt_reg;
	// Internal reset synchroniser.
	logic irst_meta_reg;
	logic irst_sync_reg;

	// The power control pin passes two flip-flops before the sequencer reads it.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			pc_meta_reg <= 1'b0;
			pc_sync_reg <= 1'b0;
		end
		else
		begin
			pc_meta_reg <= link.power_ctrl_input;
			pc_sync_reg <= pc_meta_reg;
		end
	end

	// The battery code is slow-moving; a multi-bit glitch settles within a sample.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			mv_meta_reg <= '0;
			mv_sync_reg <= '0;
		end
		else
		begin
			mv_meta_reg <= battery_supply_mv;
			mv_sync_reg <= mv_meta_reg;
		end
	end

	// The comparator is on at power up until the reset sequencer first reaches run, then
	// only by firmware or by the low power auto-enable.
	assign mon_en = !powered_once_reg || fw_blackout_en || auto_en_reg;

	// Power-up pass flag: once set, the default enable is withdrawn.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			powered_once_reg <= 1'b0;
		end
		else if (rst_state_reg == pcr_pkg::RST_RUN)
		begin
			powered_once_reg <= 1'b1;
		end
	end

	// Brownout in low power turns the comparator on; leaving low power withdraws it.
	// A brownout in the same cycle as the exit is lost, since the exit clears the enable.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			auto_en_reg <= 1'b0;
		end
		else if (low_power_mode && brownout_event)
		begin
			auto_en_reg <= 1'b1;
		end
		else if (!low_power_mode)
		begin
			auto_en_reg <= 1'b0;
		end
	end

	// Blackout comparator with hysteresis. The first rise at power up releases at
	// the power-up threshold; later recoveries need the upper threshold.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			blackout_reg <= `PCR_BLACKOUT_RST;
		end
		else if (!mon_en)
		begin
			// A disabled comparator cannot report blackout.
			blackout_reg <= 1'b0;
		end
		else if (mv_sync_reg < `PCR_BLACKOUT_LOW_MV)
		begin
			blackout_reg <= 1'b1;
		end
		else if (!powered_once_reg && mv_sync_reg >= `PCR_POWERUP_MV)
		begin
			blackout_reg <= 1'b0;
		end
		else if (mv_sync_reg > `PCR_BLACKOUT_HIGH_MV)
		begin
			blackout_reg <= 1'b0;
		end
	end

	// Supply monitor output is high unless the enabled comparator reports blackout; in loopback it
	// pulls power control low and so resets the chip on its own.
	assign link.supply_monitor_output = !blackout_reg;
	assign io_safe_hold = blackout_reg;
	assign blackout_active = blackout_reg;
	assign monitor_enabled = mon_en;

	// Internal reset: power control low, or a blackout, clears both stages at once;
	// release walks through two flops so every block leaves reset on a clock edge.
	always_ff @(posedge ref_clk or negedge link.power_ctrl_input)
	begin
		if (!link.power_ctrl_input)
		begin
			irst_meta_reg <= 1'b0;
			irst_sync_reg <= 1'b0;
		end
		else if (!rstn || blackout_reg)
		begin
			irst_meta_reg <= 1'b0;
			irst_sync_reg <= 1'b0;
		end
		else
		begin
			irst_meta_reg <= 1'b1;
			irst_sync_reg <= irst_meta_reg;
		end
	end

	assign blocks_rst_n = irst_sync_reg;

	// Chip reset pin sequencer: hold while control is low, count the release delay
	// after it rises, then let the pin float high.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			rst_state_reg <= pcr_pkg::RST_HOLD;
		end
		else
		begin
			case (rst_state_reg)
				pcr_pkg::RST_HOLD:
				begin
					if (pc_sync_reg)
					begin
						rst_state_reg <= pcr_pkg::RST_DELAY;
					end
				end
				pcr_pkg::RST_DELAY:
				begin
					if (!pc_sync_reg)
					begin
						rst_state_reg <= pcr_pkg::RST_HOLD;
					end
					else if (delay_cnt_reg == RELEASE_DELAY_CYC - 1)
					begin
						rst_state_reg <= pcr_pkg::RST_RUN;
					end
				end
				pcr_pkg::RST_RUN:
				begin
					if (!pc_sync_reg)
					begin
						rst_state_reg <= pcr_pkg::RST_HOLD;
					end
				end
				default:
				begin
					rst_state_reg <= pcr_pkg::RST_HOLD;
				end
			endcase
		end
	end

	// Release delay counter; it restarts whenever the sequencer is not delaying.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || rst_state_reg != pcr_pkg::RST_DELAY)
		begin
			delay_cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			delay_cnt_reg <= delay_cnt_reg + 32'h0000_0001;
		end
	end

	// Open-drain chip reset: drive low in every state except running.
	assign link.reset_pin_o = 1'b0;
	assign link.reset_pin_oe = (rst_state_reg != pcr_pkg::RST_RUN);
	assign chip_running = (rst_state_reg == pcr_pkg::RST_RUN);

endmodule

// ---- pcr_defs.svh ----
// Timing counts, thresholds and reset values of the power-on control and reset pair.
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

// Reference clock rate in MHz; cycle counts below are a time in us times this rate.
`define PCR_CLK_MHZ 250

// Battery code width in millivolts and the comparator thresholds.
`define PCR_MV_W 12
`define PCR_POWERUP_MV 12'h0640
`define PCR_BLACKOUT_LOW_MV 12'h0640
`define PCR_BLACKOUT_HIGH_MV 12'h0659

// Delay from power control rising to chip reset release, in us and cycles.
`define PCR_RELEASE_US 2000
`define PCR_RELEASE_CYC (`PCR_RELEASE_US * `PCR_CLK_MHZ)

// Least hold of power control for a host reset, in us and cycles.
`define PCR_EXT_RESET_US 10000
`define PCR_EXT_RESET_CYC (`PCR_EXT_RESET_US * `PCR_CLK_MHZ)

// Least hold of power control after supplies settle, in us and cycles.
`define PCR_SETTLE_US 600
`define PCR_SETTLE_CYC (`PCR_SETTLE_US * `PCR_CLK_MHZ)

// Least lead of the other supplies before chip reset release, in us and cycles.
`define PCR_SUPPLY_LEAD_US 1000
`define PCR_SUPPLY_LEAD_CYC (`PCR_SUPPLY_LEAD_US * `PCR_CLK_MHZ)

// Reset values of the blackout monitor state.
`define PCR_MON_EN_RST 1'b1
`define PCR_BLACKOUT_RST 1'b1

`endif

// ---- pcr_pkg.sv ----
// Types shared by both ends of the power-on control and reset link.
package pcr_pkg;

	// Chip reset pin sequencing states of the device end.
	typedef enum logic [1:0] {
		RST_HOLD,
		RST_DELAY,
		RST_RUN
	} pcr_rst_state_t;

	// Supply and power control sequencing states of the host end.
	typedef enum logic [2:0] {
		H_OFF,
		H_BATT_UP,
		H_SETTLE,
		H_ON,
		H_EXT_RESET,
		H_DOWN_CTRL,
		H_DOWN_OTHER
	} pcr_host_state_t;

endpackage

// ---- pcr_link_if.sv ----
// Pin-level link between the host controller and the power-on control and reset logic.
`timescale 1ns/1ps

interface pcr_link_if;

	// Supply enables driven by the host.
	logic battery_en;
	logic other_en;

	// Board strap: supply monitor output wired back to power control.
	logic loopback_en;

	// Host drive of the open-drain power control line.
	logic power_ctrl_o;
	logic power_ctrl_oe;

	// Device outputs: supply monitor level and open-drain chip reset.
	logic supply_monitor_output;
	logic reset_pin_o;
	logic reset_pin_oe;

	// Resolved wire levels; both lines are wired-AND with a pull-up.
	logic power_ctrl_input;
	logic reset_pin_level;

	assign power_ctrl_input = ~((power_ctrl_oe & ~power_ctrl_o) |
		(loopback_en & ~supply_monitor_output));
	assign reset_pin_level = ~(reset_pin_oe & ~reset_pin_o);

	// The documented device end.
	modport device (
		input power_ctrl_input,
		output supply_monitor_output,
		output reset_pin_o,
		output reset_pin_oe
	);

	// The host controller end.
	modport host (
		output battery_en,
		output other_en,
		output loopback_en,
		output power_ctrl_o,
		output power_ctrl_oe,
		input reset_pin_level
	);

endinterface

// ---- pcr_host.sv ----
// Host end: supply sequencing and external control of the power control line.
`include "pcr_defs.svh"
`timescale 1ns/1ps

module pcr_host #(
	parameter bit LOOPBACK = 1'b1,
	parameter bit EXT_CTRL = 1'b1,
	parameter int unsigned EXT_RESET_CYC = `PCR_EXT_RESET_CYC,
	parameter int unsigned SETTLE_CYC = `PCR_SETTLE_CYC,
	parameter int unsigned SUPPLY_LEAD_CYC = `PCR_SUPPLY_LEAD_CYC
) (
	// Clock and synchronous active-low reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Link pins.
	pcr_link_if.host link,
	// User requests, one-cycle pulses.
	input wire logic power_on_req,
	input wire logic power_off_req,
	input wire logic ext_reset_req,
	// Status.
	output logic busy,
	output logic supplies_on,
	output logic chip_running
);

	// Every hold must last at least one cycle to be meaningful.
	generate
		if (EXT_RESET_CYC < 1 || SETTLE_CYC < 1 || SUPPLY_LEAD_CYC < 1)
		begin : g_bad_count
			$error("pcr_host: hold counts must be at least 1");
		end
	endgenerate

	pcr_pkg::pcr_host_state_t state_reg;
	logic [31:0] cnt_reg;
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic drive_low;
	logic cnt_done;
	logic [31:0] hold_len;

	// The chip reset pin passes two flip-flops before anything reads it.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= link.reset_pin_level;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// Hold length of the current state; without external control only the power
	// down step waits, for the supply lead so removal is not abrupt.
	always_comb
	begin
		case (state_reg)
			pcr_pkg::H_SETTLE: hold_len = SETTLE_CYC;
			pcr_pkg::H_EXT_RESET: hold_len = EXT_RESET_CYC;
			default: hold_len = SUPPLY_LEAD_CYC;
		endcase
	end

	assign cnt_done = (cnt_reg >= hold_len - 1);

	// Supply and control sequencer.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			state_reg <= pcr_pkg::H_OFF;
		end
		else
		begin
			case (state_reg)
				pcr_pkg::H_OFF:
				begin
					if (power_on_req)
					begin
						state_reg <= pcr_pkg::H_BATT_UP;
					end
				end
				pcr_pkg::H_BATT_UP:
				begin
					// Battery is on one cycle ahead of the others.
					state_reg <= EXT_CTRL ? pcr_pkg::H_SETTLE : pcr_pkg::H_ON;
				end
				pcr_pkg::H_SETTLE:
				begin
					if (cnt_done)
					begin
						state_reg <= pcr_pkg::H_ON;
					end
				end
				pcr_pkg::H_ON:
				begin
					if (power_off_req)
					begin
						state_reg <= EXT_CTRL ? pcr_pkg::H_DOWN_CTRL : pcr_pkg::H_DOWN_OTHER;
					end
					else if (ext_reset_req && EXT_CTRL)
					begin
						state_reg <= pcr_pkg::H_EXT_RESET;
					end
				end
				pcr_pkg::H_EXT_RESET:
				begin
					if (cnt_done)
					begin
						state_reg <= pcr_pkg::H_ON;
					end
				end
				pcr_pkg::H_DOWN_CTRL:
				begin
					// Control goes low for one cycle before any supply is removed.
					state_reg <= pcr_pkg::H_DOWN_OTHER;
				end
				pcr_pkg::H_DOWN_OTHER:
				begin
					if (cnt_done)
					begin
						state_reg <= pcr_pkg::H_OFF;
					end
				end
				default:
				begin
					state_reg <= pcr_pkg::H_OFF;
				end
			endcase
		end
	end

	// Hold counter; it restarts on every state change. The one-cycle states clear it
	// too, otherwise the counted state after them would start one count short.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || cnt_done || state_reg == pcr_pkg::H_OFF || state_reg == pcr_pkg::H_ON ||
			state_reg == pcr_pkg::H_BATT_UP || state_reg == pcr_pkg::H_DOWN_CTRL)
		begin
			cnt_reg <= 32'h0000_0000;
		end
		else
		begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
		end
	end

	// Other supplies go off first and the battery last.
	assign link.battery_en = (state_reg != pcr_pkg::H_OFF);
	assign link.other_en = (state_reg != pcr_pkg::H_OFF) && (state_reg != pcr_pkg::H_BATT_UP) &&
		(state_reg != pcr_pkg::H_DOWN_OTHER);

	// Power control is pulled low while settling, resetting and powering down.
	assign drive_low = EXT_CTRL && ((state_reg == pcr_pkg::H_OFF) ||
		(state_reg == pcr_pkg::H_BATT_UP) || (state_reg == pcr_pkg::H_SETTLE) ||
		(state_reg == pcr_pkg::H_EXT_RESET) || (state_reg == pcr_pkg::H_DOWN_CTRL) ||
		(state_reg == pcr_pkg::H_DOWN_OTHER));
	assign link.power_ctrl_o = 1'b0;
	assign link.power_ctrl_oe = drive_low;
	assign link.loopback_en = LOOPBACK;

	assign busy = (state_reg != pcr_pkg::H_OFF) && (state_reg != pcr_pkg::H_ON);
	assign supplies_on = link.other_en;
	assign chip_running = rst_sync_reg;

endmodule

// ---- pcr_link_chk.sv ----
// Checker of the link signals between the host and device ends.
`timescale 1ns/1ps

module pcr_link_chk #(
	parameter int unsigned RELEASE_DELAY_CYC = 20,
	parameter int unsigned EXT_RESET_CYC = 40,
	parameter int unsigned SETTLE_CYC = 30,
	parameter int unsigned SUPPLY_LEAD_CYC = 10
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rstn,
	// Link signals.
	input wire logic battery_en,
	input wire logic other_en,
	input wire logic loopback_en,
	input wire logic power_ctrl_oe,
	input wire logic supply_monitor_output,
	input wire logic reset_pin_oe,
	input wire logic power_ctrl_input,
	input wire logic reset_pin_level
);
	// Run lengths of control high, other supplies on and host drive.
	int hi_cnt;
	int oth_cnt;
	int ext_cnt;
	// Set while a host drive started with the supplies already on.
	logic ext_run;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// Counters restart with reset, so nothing from before it is credited.
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			hi_cnt <= 0;
			oth_cnt <= 0;
			ext_cnt <= 0;
			ext_run <= 1'b0;
		end
		else
		begin
			hi_cnt <= power_ctrl_input ? hi_cnt + 1 : 0;
			oth_cnt <= other_en ? oth_cnt + 1 : 0;
			ext_cnt <= power_ctrl_oe ? ext_cnt + 1 : 0;
			if (!other_en)
				ext_run <= 1'b0;
			else if (power_ctrl_oe && ext_cnt == 0)
				ext_run <= 1'b1;
		end
	end

	// Four samples of control low, enough for the two-flop sync and state.
	sequence s_ctrl_low;
		!power_ctrl_input [*4];
	endsequence
	property p_ctrl_low_resets;
		s_ctrl_low |-> reset_pin_oe;
	endproperty
	a_ctrl_low_resets: assert property (p_ctrl_low_resets)
		else $error("reset pin free while control low");
	property p_release_delay;
		$fell(reset_pin_oe) |-> hi_cnt >= RELEASE_DELAY_CYC;
	endproperty
	a_release_delay: assert property (p_release_delay)
		else $error("reset pin released too early");
	property p_release_bound;
		hi_cnt == RELEASE_DELAY_CYC + 5 |-> !reset_pin_oe;
	endproperty
	a_release_bound: assert property (p_release_bound)
		else $error("reset pin not released");
	property p_batt_first;
		other_en |-> battery_en;
	endproperty
	a_batt_first: assert property (p_batt_first)
		else $error("other supplies on without battery");
	property p_supply_lead;
		$rose(reset_pin_level) |-> oth_cnt >= SUPPLY_LEAD_CYC;
	endproperty
	a_supply_lead: assert property (p_supply_lead)
		else $error("reset rose too soon after supplies");
	property p_settle_hold;
		$rose(power_ctrl_input) && other_en |-> oth_cnt >= SETTLE_CYC;
	endproperty
	a_settle_hold: assert property (p_settle_hold)
		else $error("control rose before settle time");
	property p_ext_hold;
		$fell(power_ctrl_oe) && ext_run |-> ext_cnt >= EXT_RESET_CYC;
	endproperty
	a_ext_hold: assert property (p_ext_hold)
		else $error("host reset too short");
	property p_blackout_reset;
		$fell(supply_monitor_output) && loopback_en |-> ##[1:5] reset_pin_oe;
	endproperty
	a_blackout_reset: assert property (p_blackout_reset)
		else $error("blackout did not reset the chip");
endmodule

// ---- power_on_control_reset_tb.sv ----
// Self-checking bench of the host and device ends joined by the link.
`include "pcr_defs.svh"
`timescale 1ns/1ps

module power_on_control_reset_tb;
	// Shortened counts keep the run brief.
	localparam int REL = 20;
	localparam int EXT = 40;
	localparam int SET = 30;
	localparam int LEAD = 10;
	// One row: battery code and the monitor level it should give.
	typedef struct {
		logic [`PCR_MV_W-1:0] mv;
		logic mon;
	} pcr_row_t;
	// Walks the hysteresis band; once dropped, 1600 mV no longer releases.
	pcr_row_t rows [6] = '{'{12'h06A4, 1'b1}, '{12'h0640, 1'b1}, '{12'h063F, 1'b0},
		'{12'h0640, 1'b0}, '{12'h0659, 1'b0}, '{12'h065A, 1'b1}};
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [`PCR_MV_W-1:0] mv = 12'h063F;
	logic fw_en = 1'b0;
	logic lp = 1'b0;
	logic bo = 1'b0;
	logic on_req = 1'b0;
	logic off_req = 1'b0;
	logic ext_req = 1'b0;
	logic blk_rst_n, safe_hold, blackout, mon_en, dev_run, busy, sup_on, host_run, mon_out;
	int n_mismatch = 0;
	int n_compared = 0;
	int n;

	pcr_link_if i_pcr_link_if ();
	assign mon_out = i_pcr_link_if.supply_monitor_output;

	pcr_device #(.RELEASE_DELAY_CYC(REL)) i_pcr_device (.ref_clk(ref_clk), .rstn(rstn),
		.link(i_pcr_link_if), .battery_supply_mv(mv), .fw_blackout_en(fw_en),
		.low_power_mode(lp), .brownout_event(bo), .blocks_rst_n(blk_rst_n),
		.io_safe_hold(safe_hold), .blackout_active(blackout), .monitor_enabled(mon_en),
		.chip_running(dev_run));
	pcr_host #(.EXT_RESET_CYC(EXT), .SETTLE_CYC(SET), .SUPPLY_LEAD_CYC(LEAD)) i_pcr_host (
		.ref_clk(ref_clk), .rstn(rstn), .link(i_pcr_link_if), .power_on_req(on_req),
		.power_off_req(off_req), .ext_reset_req(ext_req), .busy(busy),
		.supplies_on(sup_on), .chip_running(host_run));
	pcr_link_chk #(.RELEASE_DELAY_CYC(REL), .EXT_RESET_CYC(EXT), .SETTLE_CYC(SET),
		.SUPPLY_LEAD_CYC(LEAD)) i_pcr_link_chk (.ref_clk(ref_clk), .rstn(rstn),
		.battery_en(i_pcr_link_if.battery_en), .other_en(i_pcr_link_if.other_en),
		.loopback_en(i_pcr_link_if.loopback_en), .power_ctrl_oe(i_pcr_link_if.power_ctrl_oe),
		.supply_monitor_output(mon_out), .reset_pin_oe(i_pcr_link_if.reset_pin_oe),
		.power_ctrl_input(i_pcr_link_if.power_ctrl_input),
		.reset_pin_level(i_pcr_link_if.reset_pin_level));

	// Free-running reference clock, 4 ns period.
	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end

	// Counts a comparison and reports it at once if it fails.
	task automatic check(input bit ok, input string msg);
		n_compared++;
		if (!ok)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	// Waits whole cycles, then lets the edge's updates settle before sampling.
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Bounded wait for the chip running flag; n gets the cycles spent.
	task automatic wait_run(input logic v);
		n = 0;
		while (dev_run !== v)
		begin
			step(1);
			n++;
			if (n > 2000)
			begin
				check(1'b0, "wait bound spent");
				finish_test();
			end
		end
	endtask

	// Levels that both ends must show while reset is held.
	task automatic check_reset();
		check(mon_out === 1'b0 && i_pcr_link_if.reset_pin_oe === 1'b1, "pins");
		check(blk_rst_n === 1'b0 && mon_en === 1'b1, "device state");
		check(busy === 1'b0 && sup_on === 1'b0, "host state");
		check(i_pcr_link_if.power_ctrl_input === 1'b0, "control free in reset");
		$display("reset test done");
	endtask

	// Main sequence: power-up, row loop, then the awkward cases.
	initial
	begin
		step(4);
		check_reset();
		@(posedge ref_clk) rstn <= 1'b1;
		// A weak battery keeps the looped-back chip in reset.
		@(posedge ref_clk) on_req <= 1'b1;
		@(posedge ref_clk) on_req <= 1'b0;
		step(SET + REL + 20);
		check(dev_run === 1'b0 && safe_hold === 1'b1, "ran on weak battery");
		@(posedge ref_clk) mv <= 12'h0640;
		wait_run(1'b1);
		check(n >= REL, "release too early");
		step(3);
		check(host_run === 1'b1 && mon_en === 1'b0, "monitor still on");
		// A disabled monitor must ignore a low battery.
		@(posedge ref_clk) mv <= 12'h05DC;
		step(6);
		check(mon_out === 1'b1, "disabled monitor fired");
		@(posedge ref_clk) mv <= 12'h06A4;
		// Let the good code pass the synchroniser first, or the stale low code trips it.
		step(3);
		@(posedge ref_clk) fw_en <= 1'b1;
		step(2);
		check(mon_en === 1'b1, "firmware enable ignored");
		$display("power-on test done");
		foreach (rows[i])
		begin
			@(posedge ref_clk) mv <= rows[i].mv;
			step(6);
			check(mon_out === rows[i].mon && blackout === ~rows[i].mon, "monitor");
			check(safe_hold === ~rows[i].mon, "safe hold");
			if (rows[i].mon === 1'b0)
				check(blk_rst_n === 1'b0, "blocks free in blackout");
		end
		wait_run(1'b1);
		$display("row test done");
		// Brownout in low power mode turns the monitor on by itself.
		@(posedge ref_clk) fw_en <= 1'b0;
		@(posedge ref_clk) lp <= 1'b1;
		step(2);
		check(mon_en === 1'b0, "monitor on without brownout");
		@(posedge ref_clk) bo <= 1'b1;
		@(posedge ref_clk) bo <= 1'b0;
		step(2);
		check(mon_en === 1'b1, "brownout did not enable");
		@(posedge ref_clk) lp <= 1'b0;
		step(2);
		check(mon_en === 1'b0, "auto enable stuck");
		$display("brownout test done");
		// Host reset of a running chip.
		@(posedge ref_clk) ext_req <= 1'b1;
		@(posedge ref_clk) ext_req <= 1'b0;
		wait_run(1'b0);
		check(blk_rst_n === 1'b0, "blocks free in host reset");
		wait_run(1'b1);
		check(n >= EXT + REL - 2, "host reset too short");
		$display("host reset test done");
		// Power down: control first, then the supplies.
		@(posedge ref_clk) off_req <= 1'b1;
		@(posedge ref_clk) off_req <= 1'b0;
		step(LEAD + 5);
		check(busy === 1'b0 && sup_on === 1'b0, "supplies left on");
		check(i_pcr_link_if.battery_en === 1'b0 && dev_run === 1'b0, "chip still up");
		$display("power-off test done");
		// Power up again, then reset in mid-run.
		@(posedge ref_clk) on_req <= 1'b1;
		@(posedge ref_clk) on_req <= 1'b0;
		wait_run(1'b1);
		@(posedge ref_clk) rstn <= 1'b0;
		step(2);
		check_reset();
		@(posedge ref_clk) rstn <= 1'b1;
		step(2);
		finish_test();
	end
endmodule
